/* logic/fspi_core.sv */
// Serial memory target: command decode, status and protection, burst array access.
// Assumes SCK runs only while chip select is low; SI is sampled directly on SCK.
`timescale 1ns/10ps
`default_nettype none
module fspi_core (
   input  wire logic       clk_i,
   input  wire logic       reset_i,
   input  wire logic       sck_i,
   input  wire logic       cs_n_i,
   input  wire logic       si_i,
   input  wire logic       wp_n_i,
   output logic            so_o,
   output logic            so_oe_n_o,
   output logic      [7:0] status_o,
   output logic            link_idle_o
);

   import fspi_pkg::*;

   // State that lives only for one chip-select frame
   typedef struct packed {
      fspi_state_t st;
      logic [2:0]  bit_cnt;
      logic [1:0]  byte_cnt;
      logic [23:0] acc;
      logic [20:0] addr;
      logic [7:0]  tx;
      logic        tx_on;
      logic        halt;
      logic        wr_cmd;
   } fspi_frame_t;

   // State that outlives frames
   typedef struct packed {
      logic       latch;
      logic       clr_pend;
      logic       pin_en;
      logic [1:0] bp;
   } fspi_keep_t;

   localparam fspi_frame_t FRAME_RST = '{
      st:       ST_OPC,
      bit_cnt:  3'h0,
      byte_cnt: 2'h0,
      acc:      24'h000000,
      addr:     21'h000000,
      tx:       8'h00,
      tx_on:    1'b0,
      halt:     1'b0,
      wr_cmd:   1'b0
   };

   localparam fspi_keep_t KEEP_RST = '{
      latch:    1'b0,
      clr_pend: 1'b0,
      pin_en:   1'b0,
      bp:       BP_NONE
   };

   fspi_frame_t fr_q;
   fspi_frame_t fr_d;
   fspi_keep_t  kp_q;
   fspi_keep_t  kp_d;

   logic [7:0]        mem_q [0:MEM_DEPTH-1];
   logic              mem_we;
   logic [ADDR_W-1:0] mem_wa;
   logic [7:0]        byte_in;
   logic [ADDR_W-1:0] addr_in;
   logic [ADDR_W-1:0] addr_inc;
   logic              byte_end;
   logic              latch_cur;
   logic              sr_locked;
   logic [7:0]        status_byte;
   logic              wp_n_s;
   logic              frame_rst;
   logic              tx_bit;
   logic [7:0]        status_s;

   // Protected range lookup from the two block protect bits
   function automatic logic in_prot(input logic [1:0] bp, input logic [ADDR_W-1:0] a);
      logic hit;
      hit = 1'b0;
      unique case (bp)
         BP_NONE: hit = 1'b0;
         BP_QTR:  hit = (a >= PROT_QTR);
         BP_HALF: hit = (a >= PROT_HALF);
         default: hit = 1'b1;
      endcase
      return hit;
   endfunction

   assign frame_rst = reset_i | cs_n_i;

   // Protect pin is asynchronous to SCK; the opcode gives it enough edges to settle
   fspi_sync #(
      .W (1)
   ) u_wp_sync (
      .clk_i   (sck_i),
      .reset_i (reset_i),
      .d_i     (wp_n_i),
      .q_o     (wp_n_s)
   );

   // A clear requested by the last frame is applied on the first edge of the next
   assign latch_cur = kp_q.latch & ~kp_q.clr_pend;

   always_comb
   begin
      status_byte             = SR_FIXED;
      status_byte[SR_PPE_BIT] = kp_q.pin_en;
      status_byte[SR_BPH_BIT] = kp_q.bp[1];
      status_byte[SR_BPL_BIT] = kp_q.bp[0];
      status_byte[SR_LATCH_BIT] = latch_cur;
   end

   // Pin only matters when enabled; it never reaches the array path
   assign sr_locked = kp_q.pin_en & ~wp_n_s;

   assign byte_in  = {fr_q.acc[6:0], si_i};
   assign addr_in  = {fr_q.acc[19:0], si_i};
   assign addr_inc = fr_q.addr + 21'h000001;
   assign byte_end = (fr_q.bit_cnt == BIT_LAST);

   always_comb
   begin
      fr_d        = fr_q;
      kp_d        = kp_q;
      mem_we      = 1'b0;
      mem_wa      = fr_q.addr;
      fr_d.acc    = {fr_q.acc[22:0], si_i};
      fr_d.bit_cnt = fr_q.bit_cnt + 3'h1;

      unique case (fr_q.st)
         ST_OPC:
         begin
            if (fr_q.bit_cnt == 3'h0)
            begin
               kp_d.latch    = latch_cur;
               kp_d.clr_pend = 1'b0;
            end
            if (byte_end)
            begin
               unique case (byte_in)
                  OP_WR_ENA:
                  begin
                     kp_d.latch    = 1'b1;
                     kp_d.clr_pend = 1'b0;
                     fr_d.st       = ST_IGN;
                  end
                  OP_WR_DIS:
                  begin
                     kp_d.latch    = 1'b0;
                     kp_d.clr_pend = 1'b1;
                     fr_d.st       = ST_IGN;
                  end
                  OP_STAT_RD:
                  begin
                     fr_d.tx    = status_byte;
                     fr_d.tx_on = 1'b1;
                     fr_d.st    = ST_SRD;
                  end
                  OP_STAT_WR:
                  begin
                     kp_d.clr_pend = 1'b1;
                     fr_d.st       = ST_SWR;
                  end
                  OP_WRITE:
                  begin
                     kp_d.clr_pend = 1'b1;
                     fr_d.wr_cmd   = 1'b1;
                     fr_d.byte_cnt = 2'h0;
                     fr_d.st       = ST_ADDR;
                  end
                  OP_READ:
                  begin
                     fr_d.wr_cmd   = 1'b0;
                     fr_d.byte_cnt = 2'h0;
                     fr_d.st       = ST_ADDR;
                  end
                  default:
                  begin
                     fr_d.st = ST_IGN;
                  end
               endcase
            end
         end

         ST_ADDR:
         begin
            if (byte_end)
            begin
               if (fr_q.byte_cnt == ADDR_B_LAST)
               begin
                  // Upper bits of the first address byte fall off the top
                  fr_d.addr = addr_in;
                  if (fr_q.wr_cmd)
                  begin
                     fr_d.st = ST_WDATA;
                  end
                  else
                  begin
                     fr_d.tx    = mem_q[addr_in];
                     fr_d.tx_on = 1'b1;
                     fr_d.st    = ST_RDATA;
                  end
               end
               else
               begin
                  fr_d.byte_cnt = fr_q.byte_cnt + 2'h1;
               end
            end
         end

         ST_WDATA:
         begin
            // Commit right on the eighth edge; a cut byte never reaches here
            if (byte_end && !fr_q.halt)
            begin
               if (in_prot(kp_q.bp, fr_q.addr))
               begin
                  fr_d.halt = 1'b1;
               end
               else
               begin
                  mem_we    = kp_q.latch;
                  fr_d.addr = addr_inc;
               end
            end
         end

         ST_RDATA:
         begin
            // SI is don't-care here; the shift register still moves but nobody reads it
            if (byte_end)
            begin
               fr_d.addr = addr_inc;
               fr_d.tx   = mem_q[addr_inc];
            end
         end

         ST_SRD:
         begin
            if (byte_end)
            begin
               fr_d.tx = status_byte;
            end
         end

         ST_SWR:
         begin
            if (byte_end)
            begin
               // Latch bit and fixed bits are never taken from the data byte
               if (kp_q.latch && !sr_locked)
               begin
                  kp_d.pin_en = byte_in[SR_PPE_BIT];
                  kp_d.bp   = {byte_in[SR_BPH_BIT], byte_in[SR_BPL_BIT]};
               end
               fr_d.st = ST_IGN;
            end
         end

         ST_IGN:
         begin
            fr_d.st = ST_IGN;
         end
      endcase
   end

   // Frame state is wiped whenever chip select is high
   always_ff @(posedge sck_i or posedge frame_rst)
   begin
      if (frame_rst)
         fr_q <= FRAME_RST;
      else
         fr_q <= fr_d;
   end

   // Protect bits have no clear path besides a status write; reset models factory state
   always_ff @(posedge sck_i or posedge reset_i)
   begin
      if (reset_i)
         kp_q <= KEEP_RST;
      else
         kp_q <= kp_d;
   end

   // Array has no reset: its content is kept like the nonvolatile cells it models
   always_ff @(posedge sck_i)
   begin
      if (mem_we)
         mem_q[mem_wa] <= byte_in;
   end

   // Bit index counts up, data leaves MSB first
   assign tx_bit = fr_q.tx[~fr_q.bit_cnt];

   fspi_so_stage u_so (
      .sck_i     (sck_i),
      .release_i (frame_rst),
      .en_i      (fr_q.tx_on),
      .bit_i     (tx_bit),
      .so_o      (so_o),
      .so_oe_n_o (so_oe_n_o)
   );

   // Status only changes inside frames and then rests; each bit is synced as a level
   fspi_sync #(
      .W (8)
   ) u_status_sync (
      .clk_i   (clk_i),
      .reset_i (reset_i),
      .d_i     (status_byte),
      .q_o     (status_s)
   );

   // Bits of one status update can land a clock apart in the synchroniser,
   // so the mirror only takes a value that two samples in a row agree on
   typedef struct packed {
      logic [7:0] prev;
      logic [7:0] out;
   } fspi_mirror_t;

   fspi_mirror_t mr_q;
   fspi_mirror_t mr_d;

   always_comb
   begin
      mr_d      = mr_q;
      mr_d.prev = status_s;
      if (status_s == mr_q.prev)
      begin
         mr_d.out = status_s;
      end
   end

   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
         mr_q <= '0;
      else
         mr_q <= mr_d;
   end

   assign status_o = mr_q.out;

   fspi_sync #(
      .W (1)
   ) u_cs_sync (
      .clk_i   (clk_i),
      .reset_i (reset_i),
      .d_i     (cs_n_i),
      .q_o     (link_idle_o)
   );

endmodule // fspi_core
`default_nettype wire

/* logic/fspi_pkg.sv */
// Constants and types shared by the serial memory command logic.
// Assumes a single SPI target on one chip select; clk_i side only mirrors state.
package fspi_pkg;

   localparam logic [7:0]  OP_WR_ENA    = 8'h06;
   localparam logic [7:0]  OP_WR_DIS    = 8'h04;
   localparam logic [7:0]  OP_STAT_RD   = 8'h05;
   localparam logic [7:0]  OP_STAT_WR   = 8'h01;
   localparam logic [7:0]  OP_WRITE     = 8'h02;
   localparam logic [7:0]  OP_READ      = 8'h03;

   localparam int          SR_PPE_BIT   = 7;
   localparam int          SR_BPH_BIT   = 3;
   localparam int          SR_BPL_BIT   = 2;
   localparam int          SR_LATCH_BIT = 1;
   localparam logic [7:0]  SR_FIXED     = 8'h40;

   localparam int          ADDR_W       = 21;
   localparam int          MEM_DEPTH    = 2097152;
   localparam logic [20:0] PROT_QTR     = 21'h180000;
   localparam logic [20:0] PROT_HALF    = 21'h100000;
   localparam logic [1:0]  BP_NONE      = 2'h0;
   localparam logic [1:0]  BP_QTR       = 2'h1;
   localparam logic [1:0]  BP_HALF      = 2'h2;

   localparam logic [2:0]  BIT_LAST     = 3'h7;
   localparam logic [1:0]  ADDR_B_LAST  = 2'h2;

   typedef enum logic [2:0] {
      ST_OPC,
      ST_ADDR,
      ST_WDATA,
      ST_RDATA,
      ST_SRD,
      ST_SWR,
      ST_IGN
   } fspi_state_t;

endpackage

/* logic/fspi_so_stage.sv */
// Falling-edge output stage for the serial data out pin.
// Assumes en_i and bit_i come from rising-edge logic of the same SCK.
`timescale 1ns/10ps
`default_nettype none
module fspi_so_stage (
   input  wire logic sck_i,
   input  wire logic release_i,
   input  wire logic en_i,
   input  wire logic bit_i,
   output logic      so_o,
   output logic      so_oe_n_o
);

   typedef struct packed {
      logic so;
      logic oe_n;
   } fspi_so_t;

   fspi_so_t o_q;
   fspi_so_t o_d;

   // In mode 3 the first falling edge comes before any data is ready; en_i is low then
   always_comb
   begin
      o_d.so   = bit_i;
      o_d.oe_n = ~en_i;
   end

   // Chip select high releases the pin at once, without waiting for a clock
   always_ff @(negedge sck_i or posedge release_i)
   begin
      if (release_i)
         o_q <= '{so: 1'b0, oe_n: 1'b1};
      else
         o_q <= o_d;
   end

   assign so_o      = o_q.so;
   assign so_oe_n_o = o_q.oe_n;

endmodule // fspi_so_stage
`default_nettype wire

/* logic/fspi_sync.sv */
// Two-flop synchroniser for levels that are quasi-static or come from pins.
// Assumes the source holds each value for several destination clocks.
`timescale 1ns/10ps
`default_nettype none
module fspi_sync #(
   parameter int W = 1
) (
   input  wire logic         clk_i,
   input  wire logic         reset_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);

   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stable;
   } fspi_sync_t;

   fspi_sync_t s_q;
   fspi_sync_t s_d;

   always_comb
   begin
      s_d.meta   = d_i;
      s_d.stable = s_q.meta;
   end

   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   assign q_o = s_q.stable;

endmodule // fspi_sync
`default_nettype wire

/* test/fspi_core_asserts.sv */
// Port-level protocol checker for fspi_core, attached by bind.
// Assumes mode 0 or mode 3 frames and at least six clk_i cycles between frames.
`timescale 1ns/10ps
`default_nettype none
module fspi_core_asserts
   import fspi_pkg::*;
(
   input wire logic       clk_i,
   input wire logic       reset_i,
   input wire logic       sck_i,
   input wire logic       cs_n_i,
   input wire logic       si_i,
   input wire logic       wp_n_i,
   input wire logic       so_o,
   input wire logic       so_oe_n_o,
   input wire logic [7:0] status_o,
   input wire logic       link_idle_o
);
   logic [2:0] up_q;
   logic [5:0] n_q;
   logic [7:0] op_q;

   always_ff @(posedge clk_i or posedge reset_i)
      if (reset_i)
         up_q <= 3'h0;
      else if (up_q != 3'h7)
         up_q <= up_q + 3'h1;

   // Rising SCK edges since select, and the opcode as shifted in
   always_ff @(posedge sck_i or posedge cs_n_i or posedge reset_i)
      if (reset_i || cs_n_i)
      begin
         n_q  <= 6'h0;
         op_q <= 8'h0;
      end
      else
      begin
         if (n_q != 6'h3F)
            n_q <= n_q + 6'h1;
         if (n_q < 6'h8)
            op_q <= {op_q[6:0], si_i};
      end

   a_reset_status: assert property (@(posedge clk_i) disable iff (reset_i)
      up_q == 3'h4 |-> status_o == 8'h40) else $error("status after reset wrong");
   a_fixed_bits: assert property (@(posedge clk_i) disable iff (reset_i)
      up_q == 3'h7 |-> status_o[6] && status_o[5:4] == 2'h0 && !status_o[0])
      else $error("fixed status bits wrong");
   a_so_released: assert property (@(posedge clk_i) disable iff (reset_i)
      $past(cs_n_i) && cs_n_i |-> so_oe_n_o) else $error("SO driven while deselected");
   a_opcode_quiet: assert property (@(posedge sck_i) disable iff (reset_i || cs_n_i)
      n_q < 6'h8 |-> so_oe_n_o) else $error("SO driven during opcode");
   a_write_quiet: assert property (@(posedge sck_i) disable iff (reset_i || cs_n_i)
      n_q >= 6'h8 && op_q != 8'h05 && op_q != OP_READ |-> so_oe_n_o)
      else $error("SO driven outside a read");
   a_status_shift: assert property (@(posedge sck_i) disable iff (reset_i || cs_n_i)
      n_q[5:3] == 3'h1 && op_q == 8'h05 |-> !so_oe_n_o && so_o == status_o[~n_q[2:0]])
      else $error("status byte on SO wrong");
   a_read_quiet: assert property (@(posedge sck_i) disable iff (reset_i || cs_n_i)
      op_q == OP_READ && n_q < 6'h20 |-> so_oe_n_o) else $error("SO driven during address");
   a_read_drive: assert property (@(posedge sck_i) disable iff (reset_i || cs_n_i)
      op_q == OP_READ && n_q == 6'h20 |-> !so_oe_n_o) else $error("read data not driven");

   c_status_read: cover property (@(posedge sck_i) op_q == 8'h05 && n_q == 6'h10);
   c_status_write: cover property (@(posedge sck_i) op_q == 8'h01 && n_q == 6'h10);
   c_burst_read: cover property (@(posedge sck_i) op_q == OP_READ && n_q == 6'h28);
endmodule // fspi_core_asserts

bind fspi_core fspi_core_asserts i_fspi_core_asserts (.clk_i(clk_i), .reset_i(reset_i),
   .sck_i(sck_i), .cs_n_i(cs_n_i), .si_i(si_i), .wp_n_i(wp_n_i), .so_o(so_o),
   .so_oe_n_o(so_oe_n_o), .status_o(status_o), .link_idle_o(link_idle_o));
`default_nettype wire

/* test/fspi_core_tb_top.sv */
// Self-checking bench: host model frames, scoreboard of status and array.
// Assumes array content unknown until written; unwritten reads are not compared.
`timescale 1ns/10ps
`default_nettype none
module fspi_core_tb_top;
   import fspi_pkg::*;
   logic       clk_i;
   logic       reset_i;
   logic       wp_n;
   wire logic  sck, cs_n, si, so, so_oe_n, idle, rx_stb;
   wire logic  [7:0] status, rx;
   int         err_count;
   int         comparisons;
   logic [7:0] mem_m [int];
   logic [7:0] exp_q [$];
   logic       latch_m, ppe_m;
   logic [1:0] bp_m;

   initial
   begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end

   fspi_core i_fspi_core (.clk_i(clk_i), .reset_i(reset_i), .sck_i(sck), .cs_n_i(cs_n),
      .si_i(si), .wp_n_i(wp_n), .so_o(so), .so_oe_n_o(so_oe_n), .status_o(status),
      .link_idle_o(idle));
   fspi_host_model h (.sck_o(sck), .cs_n_o(cs_n), .si_o(si), .so_i(so),
      .so_oe_n_i(so_oe_n), .rx_o(rx), .rx_stb_o(rx_stb));

   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      comparisons++;
      if (g !== e)
      begin
         err_count++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic end_sim();
      $display("Checks %0d errors %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   always @(posedge rx_stb)
      chk("so_o", exp_q.size() ? exp_q.pop_front() : 8'hXX, rx);

   function automatic logic prot(input logic [20:0] a);
      return bp_m == 2'h3 || (bp_m == 2'h2 && a[20]) || (bp_m == 2'h1 && a[20:19] == 2'h3);
   endfunction

   task automatic endf();
      h.sel(1'b0);
      repeat (6) @(posedge clk_i);
      chk("status_o", {ppe_m, 3'h4, bp_m, latch_m, 1'b0}, status);
      chk("link_idle_o", 8'h01, {7'h00, idle});
   endtask

   task automatic cmd(input logic [7:0] op, input logic [7:0] d);
      h.sel(1'b1);
      h.xb(op, 8, 1'b0);
      chk("link_idle_o", 8'h00, {7'h00, idle});
      if (op == 8'h05)
         exp_q.push_back({ppe_m, 3'h4, bp_m, latch_m, 1'b0});
      if (op != 8'h06 && op != 8'h04)
         h.xb(d, 8, op == 8'h05);
      if (op == 8'h01 && latch_m && !(ppe_m && !wp_n))
         {ppe_m, bp_m} = {d[7], d[3:2]};
      latch_m = (op == 8'h06) ? 1'b1 : (op == 8'h04 || op == 8'h01) ? 1'b0 : latch_m;
      endf();
   endtask

   task automatic hdr(input logic [7:0] op, input logic [20:0] a);
      h.sel(1'b1);
      h.xb(op, 8, 1'b0);
      for (int i = 0; i < 3; i++)
         h.xb(8'({3'h7, a} >> (16 - 8 * i)), 8, 1'b0);
   endtask

   task automatic wr(input logic [20:0] a, input int n, input int part);
      logic [7:0] b;
      logic       stop;
      stop = 1'b0;
      hdr(OP_WRITE, a);
      for (int i = 0; i < n; i++)
      begin
         b = 8'($urandom);
         h.xb(b, 8, 1'b0);
         stop |= prot(a);
         if (!stop && latch_m)
            mem_m[a] = b;
         if (!stop)
            a++;
      end
      if (part > 0)
         h.xb(8'($urandom), part, 1'b0);
      latch_m = 1'b0;
      endf();
   endtask

   task automatic rd(input logic [20:0] a, input int n);
      hdr(OP_READ, a);
      for (int i = 0; i < n; i++)
      begin
         if (mem_m.exists(a))
            exp_q.push_back(mem_m[a]);
         h.xb(8'($urandom), 8, mem_m.exists(a));
         a++;
      end
      endf();
   endtask

   initial
   begin
      reset_i = 1'b1;
      wp_n = 1'b1;
      latch_m = 1'b0;
      ppe_m = 1'b0;
      bp_m = 2'h0;
      err_count = 0;
      comparisons = 0;
      void'($urandom(32'hE43D));
      repeat (20) @(posedge clk_i);
      reset_i <= 1'b0;
      repeat (6) @(posedge clk_i);
      chk("status_o", 8'h40, status);
      cmd(8'h05, 8'h00);
      cmd(8'h01, 8'hFF);
      cmd(8'h06, 8'h00);
      cmd(8'h04, 8'h00);
      cmd(8'hA5, 8'hFF);
      cmd(8'h06, 8'h00);
      wr(21'h1FFFFE, 5, 0);
      cmd(8'h06, 8'h00);
      wr(21'h000001, 1, 4);
      wr(21'h000000, 1, 0);
      cmd(8'h06, 8'h00);
      wr(21'h17FFFE, 4, 0);
      rd(21'h1FFFFE, 6);
      // Pin low with its enable clear must not matter to any write
      @(posedge clk_i);
      wp_n <= 1'b0;
      for (int c = 0; c < 4; c++)
      begin
         cmd(8'h06, 8'h00);
         cmd(8'h01, 8'h73 | 8'(c << 2));
         cmd(8'h06, 8'h00);
         wr(21'h0FFFFF, 2, 0);
         cmd(8'h06, 8'h00);
         wr(21'h17FFFF, 3, 0);
         rd(21'h0FFFFF, 2);
         rd(21'h17FFFF, 3);
      end
      @(posedge clk_i);
      wp_n <= 1'b1;
      h.mode(1'b1);
      cmd(8'h06, 8'h00);
      cmd(8'h01, 8'h84);
      @(posedge clk_i);
      wp_n <= 1'b0;
      cmd(8'h06, 8'h00);
      cmd(8'h01, 8'h00);
      cmd(8'h06, 8'h00);
      wr(21'h000010, 1, 0);
      rd(21'h000010, 1);
      cmd(8'h05, 8'h00);
      chk("queue", 8'h00, 8'(exp_q.size()));
      end_sim();
   end

   initial
   begin
      repeat (50000) @(posedge clk_i);
      err_count++;
      end_sim();
   end
endmodule // fspi_core_tb_top
`default_nettype wire

/* test/fspi_host_model.sv */
// Behavioural SPI host in mode 0 or 3; SCK stands at its idle level outside frames.
// Assumes the bench calls sel and xb from one process only.
`timescale 1ns/10ps
`default_nettype none
module fspi_host_model (
   output logic       sck_o,
   output logic       cs_n_o,
   output logic       si_o,
   input  wire logic  so_i,
   input  wire logic  so_oe_n_i,
   output logic [7:0] rx_o,
   output logic       rx_stb_o
);
   logic cpol;

   initial
   begin
      cpol     = 1'b0;
      sck_o    = 1'b0;
      cs_n_o   = 1'b1;
      si_o     = 1'b1;
      rx_o     = 8'h00;
      rx_stb_o = 1'b0;
   end

   // Frame edge; SI flips so a released line never looks held
   task automatic sel(input logic on);
      #5;
      cs_n_o = !on;
      si_o = ~si_o;
      #11;
   endtask

   // Idle clock level; only called while deselected
   task automatic mode(input logic m);
      #5;
      cpol = m;
      sck_o = m;
      #11;
   endtask

   task automatic xb(input logic [7:0] tx, input int nb, input logic cap);
      logic [7:0] r;
      r = 8'h00;
      for (int i = 0; i < nb; i++)
      begin
         if (cpol)
            sck_o = 1'b0;
         si_o = tx[7-i];
         #16;
         sck_o = 1'b1;
         r = {r[6:0], so_oe_n_i ? 1'bx : so_i};
         #16;
         if (!cpol)
            sck_o = 1'b0;
      end
      if (cap)
      begin
         rx_o = r;
         rx_stb_o = 1'b1;
         #1;
         rx_stb_o = 1'b0;
      end
   endtask
endmodule // fspi_host_model
`default_nettype wire
